/* File: core/mca_pkg.sv */
// Constants and types shared by the command address and option select block.
// Assumes a single pclk domain and a 32-bit APB register port.
package mca_pkg;
  // Register byte offsets
  localparam logic [7:0] MCA_OFF_ADDR = 8'h00;
  localparam logic [7:0] MCA_OFF_IFSEL = 8'h04;
  localparam logic [7:0] MCA_OFF_FEC = 8'h08;
  localparam logic [7:0] MCA_OFF_CARD = 8'h0c;
  localparam logic [7:0] MCA_OFF_STAT = 8'h10;
  localparam logic [7:0] MCA_OFF_CNT = 8'h14;
  // Field positions
  localparam int MCA_ADDR_SET_BIT = 8;
  localparam int MCA_OPT_SEL_BIT = 3;
  localparam int MCA_FEC_RX_LSB = 3;
  localparam int MCA_CARD_DONE_BIT = 8;
  localparam int MCA_CARD_TMO_BIT = 9;
  localparam int MCA_CARD_OPTIF_BIT = 7;
  localparam int MCA_STAT_SLOT_LSB = 6;
  localparam int MCA_STAT_AVAIL_LSB = 9;
  localparam int MCA_CNT_DROP_LSB = 16;
  // Values after reset, special addresses and interface codes
  localparam logic [7:0] MCA_ADDR_RST = 8'h01;
  localparam logic [7:0] MCA_BCAST = 8'hff;
  localparam logic [7:0] MCA_NOADDR = 8'h00;
  localparam logic [2:0] MCA_IF_RST = 3'h0;
  localparam logic [2:0] MCA_IF_RS232 = 3'h1;
  localparam logic [2:0] MCA_FEC_TX_RST = 3'h1;
  localparam logic [2:0] MCA_FEC_RX_RST = 3'h1;
  // Error-correction function index
  localparam int MCA_FN_VIT = 0;
  localparam int MCA_FN_RS = 1;
  localparam int MCA_FN_BT = 2;
  localparam int MCA_NFN = 3;
  // Card query timeout and event counter width
  localparam int MCA_CLK_NS = 50;
  localparam int MCA_PROBE_TMO_NS = 100000;
  localparam int MCA_PROBE_CYC = MCA_PROBE_TMO_NS / MCA_CLK_NS;
  localparam int MCA_CNT_W = 16;

  typedef enum logic [1:0] {
    MCA_PR_REQ = 2'b00,
    MCA_PR_DONE = 2'b01
  } mca_probe_state_t;
endpackage

/* File: core/mca_sync.sv */
// Two-flop synchroniser for a bus of independent static levels.
// Assumes each bit is stable long enough that bitwise skew is harmless.
`timescale 1ns/1ps
module mca_sync #(
  parameter int W = 8
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] din, // Asynchronous levels
  output logic [W-1:0] dout // Synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } mca_sync_st_t;

  mca_sync_st_t st, next_st;

  always_comb
  begin
    next_st.s1 = din;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign dout = st.s2;
endmodule

/* File: core/mca_probe.sv */
// Power-up query of the installed interface card.
// Assumes synchronised ack and data; the card holds data while ack is high.
`timescale 1ns/1ps
module mca_probe
  import mca_pkg::*;
#(
  parameter int TMO_CYC = MCA_PROBE_CYC
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic ack_s, // Card answer, synchronised
  input wire logic [7:0] data_s, // Card type and options
  output logic query, // Query to card
  output logic done, // Query finished
  output logic tmo, // Card did not answer
  output logic [7:0] info // Captured card info
);
  typedef struct packed {
    mca_probe_state_t state;
    logic query;
    logic done;
    logic tmo;
    logic [7:0] info;
    logic [15:0] cnt;
  } mca_probe_st_t;

  mca_probe_st_t st, next_st;

  always_comb
  begin
    next_st = st;
    case (st.state)
      MCA_PR_REQ:
      begin
        next_st.cnt = st.cnt + 16'h0001;
        if (ack_s)
        begin
          next_st.info = data_s;
          next_st.state = MCA_PR_DONE;
          next_st.query = 1'b0;
          next_st.done = 1'b1;
        end
        else if (st.cnt == 16'(TMO_CYC - 1))
        begin
          next_st.state = MCA_PR_DONE;
          next_st.query = 1'b0;
          next_st.done = 1'b1;
          next_st.tmo = 1'b1;
        end
      end
      MCA_PR_DONE:
        next_st.query = 1'b0;
      default:
        next_st.state = MCA_PR_DONE;
    endcase
  end

  // Query starts by itself out of reset; no software step needed
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '{state: MCA_PR_REQ, query: 1'b1, done: 1'b0, tmo: 1'b0,
              info: 8'h00, cnt: 16'h0000};
    else
      st <= next_st;
  end

  assign query = st.query;
  assign done = st.done;
  assign tmo = st.tmo;
  assign info = st.info;

  property p_probe_capture;
    @(posedge pclk) disable iff (!presetn)
      (st.state == MCA_PR_REQ) && ack_s |=> done && !query && (info == $past(data_s));
  endproperty
  a_probe_capture: assert property (p_probe_capture)
    else $error("card info not captured on answer");
endmodule

/* File: core/mca_cmd_select.sv */
// Command address filter and interface/FEC option selection, APB slave.
// Assumes a packet parser on pclk and card/slot pins from outside the domain.
`timescale 1ns/1ps
module mca_cmd_select
  import mca_pkg::*;
#(
  parameter int PROBE_CYC = MCA_PROBE_CYC
) (
  input wire logic pclk, // APB clock, 20 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error, unmapped address
  input wire logic pkt_hdr_valid, // Packet header pulse
  input wire logic [7:0] pkt_hdr_addr, // Packet destination address
  output logic cmd_accept, // Packet accepted pulse
  output logic cmd_respond, // Response required pulse
  output logic cmd_drop, // Packet discarded pulse
  output logic addr_fields_en, // Packets carry address fields
  input wire logic [2:0] slot_a_caps, // Slot A functions, async
  input wire logic [2:0] slot_b_caps, // Slot B functions, async
  input wire logic card_ack, // Interface card answer, async
  input wire logic [7:0] card_data, // Interface card info, async
  output logic card_query, // Interface card query
  output logic [7:0] if_en, // One-hot on-board interface enable
  output logic opt_if_en, // Optional card interface enable
  output logic if_rate_lim, // Sync-only, 128 kbps limit
  output logic [2:0] fn_tx_en, // Per-function transmit enable
  output logic [2:0] fn_rx_en, // Per-function receive enable
  output logic [2:0] fn_slot // Per-function slot, 1 = B
);
  typedef struct packed {
    logic [7:0] cfg_addr;
    logic addr_set;
    logic [2:0] if_code;
    logic opt_sel;
    logic [2:0] fec_tx;
    logic [2:0] fec_rx;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cmd_accept;
    logic cmd_respond;
    logic cmd_drop;
    logic addr_fields_en;
    logic [MCA_CNT_W-1:0] cnt_acc;
    logic [MCA_CNT_W-1:0] cnt_drop;
    logic [7:0] if_en;
    logic opt_if_en;
    logic if_rate_lim;
    logic [2:0] fn_tx_en;
    logic [2:0] fn_rx_en;
    logic [2:0] fn_slot;
    logic [2:0] fn_avail;
  } mca_top_st_t;

  mca_top_st_t st, next_st;
  logic [2:0] cap_a;
  logic [2:0] cap_b;
  logic ack_s;
  logic [7:0] data_s;
  logic probe_done;
  logic probe_tmo;
  logic [7:0] probe_info;
  logic setup;
  logic access;
  logic [31:0] rd_data;
  logic [2:0] tx_req;
  logic [2:0] rx_req;
  logic bt_on;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return hit(a, MCA_OFF_ADDR) | hit(a, MCA_OFF_IFSEL) | hit(a, MCA_OFF_FEC) |
           hit(a, MCA_OFF_CARD) | hit(a, MCA_OFF_STAT) | hit(a, MCA_OFF_CNT);
  endfunction

  // Slot pins and card pins cross from outside the clock domain
  mca_sync #(
    .W(15)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din({slot_a_caps, slot_b_caps, card_ack, card_data}),
    .dout({cap_a, cap_b, ack_s, data_s})
  );

  mca_probe #(
    .TMO_CYC(PROBE_CYC)
  ) u_probe (
    .pclk(pclk),
    .presetn(presetn),
    .ack_s(ack_s),
    .data_s(data_s),
    .query(card_query),
    .done(probe_done),
    .tmo(probe_tmo),
    .info(probe_info)
  );

  assign setup = psel & ~penable;
  assign access = psel & penable & st.pready;

  always_comb
  begin
    rd_data = 32'h0000_0000;
    if (hit(paddr, MCA_OFF_ADDR))
    begin
      rd_data[7:0] = st.cfg_addr;
      rd_data[MCA_ADDR_SET_BIT] = st.addr_set;
    end
    else if (hit(paddr, MCA_OFF_IFSEL))
    begin
      rd_data[2:0] = st.if_code;
      rd_data[MCA_OPT_SEL_BIT] = st.opt_sel;
    end
    else if (hit(paddr, MCA_OFF_FEC))
    begin
      rd_data[2:0] = st.fec_tx;
      rd_data[MCA_FEC_RX_LSB +: 3] = st.fec_rx;
    end
    else if (hit(paddr, MCA_OFF_CARD))
    begin
      rd_data[7:0] = probe_info;
      rd_data[MCA_CARD_DONE_BIT] = probe_done;
      rd_data[MCA_CARD_TMO_BIT] = probe_tmo;
    end
    else if (hit(paddr, MCA_OFF_STAT))
    begin
      rd_data[2:0] = st.fn_tx_en;
      rd_data[MCA_FEC_RX_LSB +: 3] = st.fn_rx_en;
      rd_data[MCA_STAT_SLOT_LSB +: 3] = st.fn_slot;
      rd_data[MCA_STAT_AVAIL_LSB +: 3] = st.fn_avail;
    end
    else if (hit(paddr, MCA_OFF_CNT))
    begin
      rd_data[MCA_CNT_W-1:0] = st.cnt_acc;
      rd_data[MCA_CNT_DROP_LSB +: MCA_CNT_W] = st.cnt_drop;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.cmd_accept = 1'b0;
    next_st.cmd_respond = 1'b0;
    next_st.cmd_drop = 1'b0;
    tx_req = 3'h0;
    rx_req = 3'h0;
    bt_on = 1'b0;

    // Answer in the access cycle right after setup, no wait states
    next_st.pready = setup;
    if (setup)
    begin
      next_st.pslverr = ~addr_ok(paddr);
      next_st.prdata = rd_data;
    end
    if (access & pwrite & ~st.pslverr)
    begin
      if (hit(paddr, MCA_OFF_ADDR))
      begin
        next_st.cfg_addr = pwdata[7:0];
        next_st.addr_set = 1'b1;
      end
      if (hit(paddr, MCA_OFF_IFSEL))
      begin
        next_st.if_code = pwdata[2:0];
        // Optional interface only selectable when the card reported one
        next_st.opt_sel = pwdata[MCA_OPT_SEL_BIT] & probe_done &
                          probe_info[MCA_CARD_OPTIF_BIT];
      end
      if (hit(paddr, MCA_OFF_FEC))
      begin
        next_st.fec_tx = pwdata[2:0];
        next_st.fec_rx = pwdata[MCA_FEC_RX_LSB +: 3];
      end
    end

    // Address filter
    next_st.addr_fields_en = (st.cfg_addr != MCA_NOADDR);
    if (pkt_hdr_valid)
    begin
      if (!st.addr_set)
        next_st.cmd_drop = 1'b1;
      else if (st.cfg_addr == MCA_NOADDR)
      begin
        next_st.cmd_accept = 1'b1;
        next_st.cmd_respond = 1'b1;
      end
      else if (pkt_hdr_addr == MCA_BCAST)
        next_st.cmd_accept = 1'b1;
      else if (pkt_hdr_addr == st.cfg_addr)
      begin
        next_st.cmd_accept = 1'b1;
        next_st.cmd_respond = 1'b1;
      end
      else
        next_st.cmd_drop = 1'b1;
    end
    // Counters saturate rather than wrap so a flood stays visible
    if (st.cmd_accept && st.cnt_acc != '1)
      next_st.cnt_acc = st.cnt_acc + 1'b1;
    if (st.cmd_drop && st.cnt_drop != '1)
      next_st.cnt_drop = st.cnt_drop + 1'b1;

    // Interface enables: exactly one source or none
    next_st.if_en = 8'h00;
    if (!st.opt_sel && st.if_code != MCA_IF_RST)
      next_st.if_en[st.if_code] = 1'b1;
    next_st.opt_if_en = st.opt_sel;
    next_st.if_rate_lim = !st.opt_sel && (st.if_code == MCA_IF_RS232);

    // FEC: lowest slot wins, per function
    for (int i = 0; i < MCA_NFN; i++)
    begin
      next_st.fn_avail[i] = cap_a[i] | cap_b[i];
      next_st.fn_slot[i] = ~cap_a[i] & cap_b[i];
      tx_req[i] = st.fec_tx[i] & (cap_a[i] | cap_b[i]);
      rx_req[i] = st.fec_rx[i] & (cap_a[i] | cap_b[i]);
    end
    bt_on = tx_req[MCA_FN_BT] | rx_req[MCA_FN_BT];
    next_st.fn_tx_en = tx_req;
    next_st.fn_rx_en = rx_req;
    // Block turbo takes the convolutional/Viterbi place per direction
    next_st.fn_tx_en[MCA_FN_VIT] = tx_req[MCA_FN_VIT] & ~tx_req[MCA_FN_BT];
    next_st.fn_rx_en[MCA_FN_VIT] = rx_req[MCA_FN_VIT] & ~rx_req[MCA_FN_BT];
    // Block turbo wins over Reed-Solomon in both directions
    next_st.fn_tx_en[MCA_FN_RS] = tx_req[MCA_FN_RS] & ~bt_on;
    next_st.fn_rx_en[MCA_FN_RS] = rx_req[MCA_FN_RS] & ~bt_on;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st <= '0;
      st.cfg_addr <= MCA_ADDR_RST;
      st.addr_fields_en <= 1'b1;
      st.if_code <= MCA_IF_RST;
      st.fec_tx <= MCA_FEC_TX_RST;
      st.fec_rx <= MCA_FEC_RX_RST;
    end
    else
      st <= next_st;
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign cmd_accept = st.cmd_accept;
  assign cmd_respond = st.cmd_respond;
  assign cmd_drop = st.cmd_drop;
  assign addr_fields_en = st.addr_fields_en;
  assign if_en = st.if_en;
  assign opt_if_en = st.opt_if_en;
  assign if_rate_lim = st.if_rate_lim;
  assign fn_tx_en = st.fn_tx_en;
  assign fn_rx_en = st.fn_rx_en;
  assign fn_slot = st.fn_slot;

  property p_unset_drop;
    @(posedge pclk) disable iff (!presetn)
      pkt_hdr_valid && !st.addr_set |=> cmd_drop && !cmd_accept && !cmd_respond;
  endproperty
  a_unset_drop: assert property (p_unset_drop)
    else $error("packet accepted before address set");

  property p_bcast;
    @(posedge pclk) disable iff (!presetn)
      pkt_hdr_valid && st.addr_set && st.cfg_addr != MCA_NOADDR &&
      pkt_hdr_addr == MCA_BCAST |=> cmd_accept && !cmd_respond;
  endproperty
  a_bcast: assert property (p_bcast)
    else $error("broadcast not accepted silently");

  property p_zero;
    @(posedge pclk) disable iff (!presetn)
      pkt_hdr_valid && st.addr_set && st.cfg_addr == MCA_NOADDR
      |=> cmd_accept && cmd_respond && !addr_fields_en;
  endproperty
  a_zero: assert property (p_zero)
    else $error("address-less mode wrong");

  property p_foreign;
    @(posedge pclk) disable iff (!presetn)
      pkt_hdr_valid && st.addr_set && st.cfg_addr != MCA_NOADDR &&
      pkt_hdr_addr != MCA_BCAST && pkt_hdr_addr != st.cfg_addr
      |=> cmd_drop && !cmd_respond && !cmd_accept;
  endproperty
  a_foreign: assert property (p_foreign)
    else $error("foreign packet not dropped");

  property p_one_if;
    @(posedge pclk) disable iff (!presetn)
      $onehot0({if_en, opt_if_en});
  endproperty
  a_one_if: assert property (p_one_if)
    else $error("more than one interface enabled");

  property p_rate_lim;
    @(posedge pclk) disable iff (!presetn)
      st.if_code == MCA_IF_RS232 && !st.opt_sel |=> if_rate_lim && if_en[1];
  endproperty
  a_rate_lim: assert property (p_rate_lim)
    else $error("code 1 not limited sync serial");

  property p_slot;
    @(posedge pclk) disable iff (!presetn)
      $past(cap_a[MCA_FN_RS]) |-> !fn_slot[MCA_FN_RS];
  endproperty
  a_slot: assert property (p_slot)
    else $error("slot B chosen while slot A offers it");

  property p_bt_vit;
    @(posedge pclk) disable iff (!presetn)
      fn_tx_en[MCA_FN_BT] |-> !fn_tx_en[MCA_FN_VIT];
  endproperty
  a_bt_vit: assert property (p_bt_vit)
    else $error("Viterbi path active with block turbo");

  property p_bt_rs;
    @(posedge pclk) disable iff (!presetn)
      (fn_tx_en[MCA_FN_BT] | fn_rx_en[MCA_FN_BT]) |->
      !(fn_tx_en[MCA_FN_RS] | fn_rx_en[MCA_FN_RS]);
  endproperty
  a_bt_rs: assert property (p_bt_rs)
    else $error("block turbo and Reed-Solomon together");

  property p_apb_ready;
    @(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB answer not one cycle after setup");
endmodule

/* File: dv/mca_far_model.sv */
// Far-side model: remote controller issuing packet headers, and the interface card.
// Assumes the bench pulses send for one pclk cycle per header; card answers after card_dly.
`timescale 1ns/1ps
module mca_far_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic send, // Issue one header
  input wire logic [7:0] dest, // Header address
  output logic pkt_hdr_valid, // Header pulse
  output logic [7:0] pkt_hdr_addr, // Header address, scrambled when idle
  input wire logic card_query, // Query from the block
  input wire logic card_fit, // Card installed
  input wire logic [3:0] card_dly, // Answer delay in cycles
  input wire logic [7:0] card_info, // Type and options
  output logic card_ack, // Answer level
  output logic [7:0] card_data // Info while answering
);
  logic [3:0] cnt;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pkt_hdr_valid <= 1'b0;
      pkt_hdr_addr <= 8'h00;
      cnt <= 4'h0;
    end
    else
    begin
      pkt_hdr_valid <= send;
      // Idle address toggles so a stale value is never trusted
      pkt_hdr_addr <= send ? dest : ~pkt_hdr_addr;
      if (card_query && card_fit && cnt != 4'hf)
        cnt <= cnt + 4'h1;
      else if (!card_query)
        cnt <= 4'h0;
    end
  end

  assign card_ack = card_query && card_fit && (cnt > card_dly);
  // Released data lines show the inverse, never the held value
  assign card_data = card_ack ? card_info : ~card_info;
endmodule

/* File: dv/modem_cmd_address_and_option_select_bench.sv */
// Self-checking bench for the command address filter and option select block.
// Assumes the far-side model drives packet headers and the card answer.
`timescale 1ns/1ps
module modem_cmd_address_and_option_select_bench
  import mca_pkg::*;
;
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] dest;
    logic [5:0] fec;
    logic [2:0] pk;
    logic [2:0] tx;
    logic [2:0] rx;
  } mca_row_t;

  // Flags are accept, respond, drop; all functions fitted in the slots
  mca_row_t rows [8] = '{
    '{8'h05, 8'h05, 6'h09, 3'h6, 3'h1, 3'h1}, '{8'h05, 8'hff, 6'h0b, 3'h4, 3'h3, 3'h1},
    '{8'h05, 8'h06, 6'h0c, 3'h1, 3'h4, 3'h1}, '{8'h00, 8'h37, 6'h16, 3'h6, 3'h4, 3'h0},
    '{8'hff, 8'hff, 6'h2d, 3'h4, 3'h4, 3'h4}, '{8'hfe, 8'h05, 6'h10, 3'h1, 3'h0, 3'h2},
    '{8'h01, 8'h01, 6'h00, 3'h6, 3'h0, 3'h0}, '{8'h00, 8'hff, 6'h19, 3'h6, 3'h1, 3'h3}};

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic send, pkt_hdr_valid, cmd_accept, cmd_respond, cmd_drop, addr_fields_en, er;
  logic [7:0] dest, pkt_hdr_addr, card_data, if_en, card_info;
  logic [2:0] slot_a_caps, slot_b_caps, fn_tx_en, fn_rx_en, fn_slot;
  logic card_ack, card_query, opt_if_en, if_rate_lim, card_fit;
  logic [3:0] card_dly, pr;
  int fails = 0;
  int tests_run = 0;

  always #25 pclk = ~pclk;

  mca_cmd_select #(.PROBE_CYC(20)) u_mca_cmd_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_hdr_valid(pkt_hdr_valid), .pkt_hdr_addr(pkt_hdr_addr), .cmd_accept(cmd_accept),
    .cmd_respond(cmd_respond), .cmd_drop(cmd_drop), .addr_fields_en(addr_fields_en),
    .slot_a_caps(slot_a_caps), .slot_b_caps(slot_b_caps), .card_ack(card_ack),
    .card_data(card_data), .card_query(card_query), .if_en(if_en), .opt_if_en(opt_if_en),
    .if_rate_lim(if_rate_lim), .fn_tx_en(fn_tx_en), .fn_rx_en(fn_rx_en), .fn_slot(fn_slot));

  mca_far_model u_mca_far_model (
    .pclk(pclk), .presetn(presetn), .send(send), .dest(dest), .pkt_hdr_valid(pkt_hdr_valid),
    .pkt_hdr_addr(pkt_hdr_addr), .card_query(card_query), .card_fit(card_fit),
    .card_dly(card_dly), .card_info(card_info), .card_ack(card_ack), .card_data(card_data));

  task automatic summarize();
    $display("TB: runs %0d bad %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic give_up();
    fails++;
    $display("BAD %0t wait ran out", $time);
    summarize();
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // Answer taken at the very rising edge that sees pready high
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      give_up();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pkt(input logic [7:0] d);
    int n;
    @(posedge pclk);
    send <= 1'b1;
    dest <= d;
    @(posedge pclk);
    send <= 1'b0;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (cmd_accept !== 1'b1 && cmd_drop !== 1'b1 && n < 8);
    if (n >= 8)
      give_up();
    pr = {cmd_accept, cmd_respond, cmd_drop, addr_fields_en};
  endtask

  task automatic restart();
    int n;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({cmd_accept, cmd_respond, cmd_drop, addr_fields_en, pready, pslverr, opt_if_en,
         if_rate_lim}, 8'h10);
    chk({if_en, fn_tx_en, fn_rx_en, fn_slot, card_query}, 18'h00001);
    chk(prdata, 32'h0);
    presetn <= 1'b1;
    n = 0;
    while (card_query !== 1'b0 && n < 80)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 80)
      give_up();
  endtask

  initial
  begin
    {psel, penable, pwrite, send, paddr, pwdata, dest} <= '0;
    {slot_a_caps, slot_b_caps, card_fit, card_dly, card_info} <= {3'h3, 3'h7, 1'b1, 4'h5, 8'h83};
    restart();
    apb(1'b0, MCA_OFF_ADDR, 32'h0);
    chk(rd, 32'h1);
    pkt(8'h01);
    chk(pr[3:1], 3'h1);
    apb(1'b0, MCA_OFF_CARD, 32'h0);
    chk(rd, 32'h183);
    $display("reset and probe test done");
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, MCA_OFF_ADDR, {24'h0, rows[i].cfg});
      apb(1'b1, MCA_OFF_IFSEL, 32'(i));
      apb(1'b1, MCA_OFF_FEC, {26'h0, rows[i].fec});
      pkt(rows[i].dest);
      chk(pr[3:1], rows[i].pk);
      chk(pr[0], rows[i].cfg != 8'h00);
      chk({if_en, if_rate_lim, opt_if_en}, {(i == 0) ? 8'h0 : 8'h1 << i, i == 1, 1'b0});
      chk({fn_tx_en, fn_rx_en}, {rows[i].tx, rows[i].rx});
    end
    $display("row table done");
    apb(1'b0, MCA_OFF_CNT, 32'h0);
    chk(rd, 32'h0003_0006);
    apb(1'b1, MCA_OFF_IFSEL, 32'h0a);
    // Enables follow the register one edge after the write lands
    repeat (2) @(negedge pclk);
    chk({if_en, opt_if_en}, 9'h001);
    apb(1'b0, 8'h20, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    slot_a_caps <= 3'h5;
    apb(1'b1, MCA_OFF_FEC, 32'h24);
    repeat (4) @(posedge pclk);
    chk({fn_tx_en, fn_rx_en, fn_slot[2]}, {3'h4, 3'h4, 1'b0});
    slot_a_caps <= 3'h1;
    repeat (5) @(posedge pclk);
    chk({fn_tx_en, fn_slot[2]}, {3'h4, 1'b1});
    apb(1'b0, MCA_OFF_STAT, 32'h0);
    chk(rd, 32'h0000_0fa4);
    $display("option and slot test done");
    // Absent card: the probe must give up on its own
    card_fit <= 1'b0;
    restart();
    apb(1'b0, MCA_OFF_CARD, 32'h0);
    chk(rd[MCA_CARD_TMO_BIT], 1'b1);
    apb(1'b1, MCA_OFF_IFSEL, 32'h0a);
    repeat (2) @(negedge pclk);
    chk({if_en, opt_if_en}, 9'h008);
    pkt(8'hff);
    chk(pr[3:1], 3'h1);
    $display("card timeout test done");
    summarize();
  end
endmodule
